// ==== rtl/dbg_cmp_pkg.sv ====
// constants and types shared by the bus debug comparator and trace block
package dbg_cmp_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_ONE   = 6'h20;
  localparam logic [5:0] IDX_STATE_FLG  = 6'h21;
  localparam logic [5:0] IDX_TRACE_CTL  = 6'h22;
  localparam logic [5:0] IDX_RANGE_CFG  = 6'h23;
  localparam logic [5:0] IDX_TRACE_HI   = 6'h24;
  localparam logic [5:0] IDX_TRACE_LO   = 6'h25;
  localparam logic [5:0] IDX_TRACE_CNT  = 6'h26;
  localparam logic [5:0] IDX_SEQ_MATCH  = 6'h27;
  localparam logic [5:0] IDX_CMP_CTL    = 6'h28;
  localparam logic [5:0] IDX_CMP_ADDR_H = 6'h29;
  localparam logic [5:0] IDX_CMP_ADDR_M = 6'h2a;
  localparam logic [5:0] IDX_CMP_ADDR_L = 6'h2b;
  localparam logic [5:0] IDX_CMP_DATA_H = 6'h2c;
  localparam logic [5:0] IDX_CMP_DATA_L = 6'h2d;
  localparam int         AXI_ADDR_W     = 8;

  // field positions
  localparam int CTL1_ARM   = 7;
  localparam int CTL1_TRIG  = 6;
  localparam int CTL1_BRKEN = 3;
  localparam int TRC_SRC    = 6;
  localparam int TRC_MODE   = 2;
  localparam int CC_SIZE_EN = 7;
  localparam int CC_SIZE    = 6;
  localparam int CC_RW      = 3;
  localparam int CC_DIR_EN  = 2;
  localparam int CC_NO_DATA = 1;
  localparam int CC_ENABLE  = 0;

  // writable bits of each comparator control and other registers
  localparam logic [7:0] CTL_MASK_A  = 8'hff;
  localparam logic [7:0] CTL_MASK_B  = 8'hfd;
  localparam logic [7:0] CTL_MASK_C  = 8'h3d;
  localparam logic [7:0] CTL1_MASK   = 8'h8b;
  localparam logic [7:0] TRCCTL_MASK = 8'h4d;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {VIEW_A = 2'b00, VIEW_B = 2'b01, VIEW_C = 2'b10,
                            VIEW_NONE = 2'b11} view_e;
  typedef enum logic [1:0] {TM_NORMAL = 2'b00, TM_LOOP1 = 2'b01, TM_DETAIL = 2'b10,
                            TM_PURE_PC = 2'b11} trace_mode_e;
  typedef enum logic [1:0] {RM_AB = 2'b00, RM_INSIDE = 2'b01, RM_OUTSIDE = 2'b10,
                            RM_RSVD = 2'b11} range_mode_e;
  typedef enum logic [2:0] {SEQ_IDLE = 3'b000, SEQ_ARMED = 3'b001,
                            SEQ_TRACE = 3'b100} seq_e;

endpackage

// ==== rtl/bus_debug_comparator_trace.sv ====
// bus debug comparators with range match and 16-bit trace buffer, AXI4-Lite registers
`timescale 1ns/1ps
module bus_debug_comparator_trace #(
  parameter int TRACE_DEPTH = 64
) (
  input  wire logic                               I_SYS_CLK,
  input  wire logic                               I_RESETN,
  input  wire logic [dbg_cmp_pkg::AXI_ADDR_W-1:0] I_AWADDR,
  input  wire logic                               I_AWVALID,
  output logic                                    O_AWREADY,
  input  wire logic [31:0]                        I_WDATA,
  input  wire logic [3:0]                         I_WSTRB,
  input  wire logic                               I_WVALID,
  output logic                                    O_WREADY,
  output logic [1:0]                              O_BRESP,
  output logic                                    O_BVALID,
  input  wire logic                               I_BREADY,
  input  wire logic [dbg_cmp_pkg::AXI_ADDR_W-1:0] I_ARADDR,
  input  wire logic                               I_ARVALID,
  output logic                                    O_ARREADY,
  output logic [31:0]                             O_RDATA,
  output logic [1:0]                              O_RRESP,
  output logic                                    O_RVALID,
  input  wire logic                               I_RREADY,
  input  wire logic                               I_BUS_VALID,
  input  wire logic [17:0]                        I_BUS_ADDR,
  input  wire logic [15:0]                        I_BUS_DATA,
  input  wire logic                               I_BUS_WRITE,
  input  wire logic                               I_BUS_WORD,
  input  wire logic                               I_CHIP_UNSECURE,
  output logic [2:0]                              O_MATCH,
  output logic                                    O_BREAK_REQ,
  output logic                                    O_ARMED
);
  import dbg_cmp_pkg::*;

  localparam int CW = $clog2(TRACE_DEPTH);

  initial
  begin
    if (TRACE_DEPTH < 2 || TRACE_DEPTH > 64 || (1 << CW) != TRACE_DEPTH)
      $error("TRACE_DEPTH must be a power of two from 2 to 64");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_one_q;
  logic [7:0]  trace_ctl_q;
  logic [1:0]  range_q;
  logic [3:0]  seq_ctl_q;
  logic [7:0]  cmp_ctl_q  [3];
  logic [17:0] cmp_addr_q [3];
  logic [15:0] cmp_data_q;
  logic [2:0]  mflag_q;
  logic        unlock_q;
  seq_e        seq_q;
  logic        armed;
  view_e       view;
  trace_mode_e tmode;
  range_mode_e rmode;

  assign armed = seq_q != SEQ_IDLE;
  assign view  = view_e'(ctrl_one_q[1:0]);
  assign tmode = trace_mode_e'(trace_ctl_q[TRC_MODE +: 2]);
  assign rmode = range_mode_e'(range_q);

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic [5:0]  aw_idx_q;
  logic        aw_full_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_full_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        do_wr;
  logic        wr_map;

  assign O_AWREADY = !aw_full_q && !bvalid_q;
  assign O_WREADY  = !w_full_q && !bvalid_q;
  assign do_wr     = aw_full_q && w_full_q;
  assign wr_map    = aw_idx_q >= IDX_CTRL_ONE && aw_idx_q <= IDX_CMP_DATA_L;
  assign O_BVALID  = bvalid_q;
  assign O_BRESP   = bresp_q;

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_idx_q  <= 6'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_full_q <= 1'b1;
        aw_idx_q  <= I_AWADDR[7:2];
      end
      if (I_WVALID && O_WREADY)
      begin
        w_full_q <= 1'b1;
        wdata_q  <= I_WDATA;
        wstrb_q  <= I_WSTRB;
      end
      if (do_wr)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && I_BREADY)
        bvalid_q <= 1'b0;
    end
  end

  logic       wr_b0;
  logic [7:0] wb;
  assign wr_b0 = do_wr && wstrb_q[0];
  assign wb    = wdata_q[7:0];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ctrl_one_q  <= RESET_BYTE;
      trace_ctl_q <= RESET_BYTE;
      range_q     <= 2'b00;
      seq_ctl_q   <= 4'h0;
      cmp_data_q  <= 16'h0000;
    end
    else
    begin
      if (wr_b0 && aw_idx_q == IDX_CTRL_ONE)
        ctrl_one_q <= wb & CTL1_MASK;
      if (wr_b0 && !armed && aw_idx_q == IDX_TRACE_CTL)
        trace_ctl_q <= wb & TRCCTL_MASK;
      if (wr_b0 && !armed && aw_idx_q == IDX_RANGE_CFG)
        range_q <= wb[1:0];
      if (wr_b0 && !armed && aw_idx_q == IDX_SEQ_MATCH)
        seq_ctl_q <= wb[3:0];
      if (wr_b0 && !armed && aw_idx_q == IDX_CMP_DATA_H)
        cmp_data_q[15:8] <= wb;
      if (wr_b0 && !armed && aw_idx_q == IDX_CMP_DATA_L)
        cmp_data_q[7:0] <= wb;
    end
  end

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  logic [2:0] hit;

  for (genvar k = 0; k < 3; k++)
  begin : g_cmp
    localparam logic [7:0] MASK = (k == 0) ? CTL_MASK_A : (k == 1) ? CTL_MASK_B : CTL_MASK_C;
    logic sel;
    logic rw_ok;
    logic sz_ok;
    logic dat_ok;
    assign sel = !armed && view == view_e'(k[1:0]);

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
      if (!I_RESETN)
      begin
        cmp_ctl_q[k]  <= RESET_BYTE;
        cmp_addr_q[k] <= 18'h0_0000;
      end
      else if (wr_b0 && sel)
      begin
        if (aw_idx_q == IDX_CMP_CTL)
          cmp_ctl_q[k] <= wb & MASK;
        if (aw_idx_q == IDX_CMP_ADDR_H)
          cmp_addr_q[k][17:16] <= wb[1:0];
        if (aw_idx_q == IDX_CMP_ADDR_M)
          cmp_addr_q[k][15:8] <= wb;
        if (aw_idx_q == IDX_CMP_ADDR_L)
          cmp_addr_q[k][7:0] <= wb;
      end
    end

    assign rw_ok  = !cmp_ctl_q[k][CC_DIR_EN] || (cmp_ctl_q[k][CC_RW] == !I_BUS_WRITE);
    assign sz_ok  = !cmp_ctl_q[k][CC_SIZE_EN] || (cmp_ctl_q[k][CC_SIZE] == I_BUS_WORD);
    // data compare only on comparator A, skipped when its no-data-bus bit is set
    assign dat_ok = (k != 0) || cmp_ctl_q[k][CC_NO_DATA] || (I_BUS_DATA == cmp_data_q);
    assign hit[k] = I_BUS_VALID && cmp_ctl_q[k][CC_ENABLE] && rw_ok && sz_ok && dat_ok
                    && I_BUS_ADDR == cmp_addr_q[k];
  end

  // range test uses only A and B addresses; A enable gates it
  logic       in_range;
  logic [2:0] match;
  assign in_range = I_BUS_ADDR >= cmp_addr_q[0] && I_BUS_ADDR <= cmp_addr_q[1];

  always_comb
  begin
    match[2] = hit[2];
    case (rmode)
      RM_AB:
      begin
        match[0] = hit[0];
        match[1] = hit[1];
      end
      RM_INSIDE:
      begin
        match[0] = I_BUS_VALID && cmp_ctl_q[0][CC_ENABLE] && in_range;
        match[1] = 1'b0;
      end
      RM_OUTSIDE:
      begin
        match[0] = I_BUS_VALID && cmp_ctl_q[0][CC_ENABLE] && !in_range;
        match[1] = 1'b0;
      end
      default:
      begin
        match[0] = hit[0];
        match[1] = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer, match flags, break
  // ----------------------------------------------------------------
  logic          arm_wr;
  logic          disarm_wr;
  logic          trig_wr;
  logic [CW:0]   cnt_q;
  logic          full;
  logic          rec;
  assign arm_wr    = wr_b0 && aw_idx_q == IDX_CTRL_ONE && wb[CTL1_ARM];
  assign disarm_wr = wr_b0 && aw_idx_q == IDX_CTRL_ONE && !wb[CTL1_ARM];
  assign trig_wr   = wr_b0 && aw_idx_q == IDX_CTRL_ONE && wb[CTL1_TRIG];
  assign full      = cnt_q[CW];

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      seq_q <= SEQ_IDLE;
    else
      case (seq_q)
        SEQ_IDLE:  seq_q <= arm_wr ? SEQ_ARMED : SEQ_IDLE;
        SEQ_ARMED: seq_q <= disarm_wr ? SEQ_IDLE
                          : (match[0] || trig_wr) ? SEQ_TRACE : SEQ_ARMED;
        SEQ_TRACE: seq_q <= (disarm_wr || full) ? SEQ_IDLE : SEQ_TRACE;
        default:   seq_q <= SEQ_IDLE;
      endcase
  end

  // flags clear on arming; a match in the same cycle is not recorded, since armed is still low
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      mflag_q     <= 3'b000;
      O_BREAK_REQ <= 1'b0;
      O_MATCH     <= 3'b000;
    end
    else
    begin
      mflag_q     <= ((seq_q == SEQ_IDLE && arm_wr) ? 3'b000 : mflag_q)
                     | (armed ? match : 3'b000);
      O_BREAK_REQ <= armed && ctrl_one_q[CTL1_BRKEN] && |match;
      O_MATCH     <= armed ? match : 3'b000;
    end
  end
  assign O_ARMED = armed;

  // ----------------------------------------------------------------
  // trace buffer; storage has no reset so contents survive it
  // ----------------------------------------------------------------
  logic [15:0]   tb_mem [TRACE_DEPTH];
  logic [CW-1:0] rd_ptr_q;
  logic [15:0]   last_q;
  logic [17:0]   prev_addr_q;
  logic [15:0]   entry;
  logic          rd_ok;
  logic          tb_rd;

  always_comb
  begin
    entry = I_BUS_ADDR[15:0];
    rec   = 1'b0;
    if (seq_q == SEQ_TRACE && I_BUS_VALID && trace_ctl_q[TRC_SRC] && !full)
      case (tmode)
        TM_NORMAL:  rec = 1'b1;
        TM_LOOP1:   rec = entry != last_q;
        TM_DETAIL:
        begin
          entry = I_BUS_DATA;
          rec   = 1'b1;
        end
        TM_PURE_PC: rec = I_BUS_ADDR != prev_addr_q + 18'h0_0001;
        default:    rec = 1'b0;
      endcase
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (rec)
      tb_mem[cnt_q[CW-1:0]] <= entry;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      cnt_q       <= '0;
      last_q      <= 16'h0000;
      prev_addr_q <= 18'h0_0000;
    end
    else
    begin
      if (seq_q == SEQ_IDLE && arm_wr)
        cnt_q <= '0;
      else if (rec)
        cnt_q <= cnt_q + 1'b1;
      if (rec)
        last_q <= entry;
      if (I_BUS_VALID)
        prev_addr_q <= I_BUS_ADDR;
    end
  end

  assign rd_ok = unlock_q && I_CHIP_UNSECURE && !armed && trace_ctl_q[TRC_SRC];

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      unlock_q <= 1'b0;
      rd_ptr_q <= '0;
    end
    else
    begin
      // word write only unlocks; it never touches stored entries
      if (do_wr && !armed && aw_idx_q == IDX_TRACE_HI && wstrb_q[1:0] == 2'b11)
        unlock_q <= 1'b1;
      else if (arm_wr)
        unlock_q <= 1'b0;
      if (arm_wr)
        rd_ptr_q <= '0;
      else if (tb_rd)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [5:0]  ar_idx;
  logic [31:0] rd_mux;
  logic        rd_map;
  logic [7:0]  cnt_byte;
  logic        vis;
  logic [1:0]  vi;
  assign ar_idx    = I_ARADDR[7:2];
  assign O_ARREADY = !O_RVALID;
  assign tb_rd     = I_ARVALID && O_ARREADY && ar_idx == IDX_TRACE_HI && rd_ok;
  assign cnt_byte  = {full, 7'(cnt_q)};
  assign vis       = view != VIEW_NONE;
  assign vi        = vis ? view : 2'b00;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_map = 1'b1;
    case (ar_idx)
      IDX_CTRL_ONE:   rd_mux[7:0] = {armed, ctrl_one_q[6:0]};
      IDX_STATE_FLG:  rd_mux[7:0] = {full, 4'h0, seq_q};
      IDX_TRACE_CTL:  rd_mux[7:0] = trace_ctl_q;
      IDX_RANGE_CFG:  rd_mux[7:0] = {6'h00, range_q};
      IDX_TRACE_HI:   rd_mux[15:0] = rd_ok ? tb_mem[rd_ptr_q] : 16'h0000;
      IDX_TRACE_LO:   rd_mux[7:0] = rd_ok ? tb_mem[rd_ptr_q][7:0] : 8'h00;
      IDX_TRACE_CNT:  rd_mux[7:0] = cnt_byte;
      IDX_SEQ_MATCH:  rd_mux[7:0] = armed ? {5'h00, mflag_q} : {4'h0, seq_ctl_q};
      IDX_CMP_CTL:    rd_mux[7:0] = vis ? cmp_ctl_q[vi] : 8'h00;
      IDX_CMP_ADDR_H: rd_mux[7:0] = vis ? {6'h00, cmp_addr_q[vi][17:16]} : 8'h00;
      IDX_CMP_ADDR_M: rd_mux[7:0] = vis ? cmp_addr_q[vi][15:8] : 8'h00;
      IDX_CMP_ADDR_L: rd_mux[7:0] = vis ? cmp_addr_q[vi][7:0] : 8'h00;
      IDX_CMP_DATA_H: rd_mux[7:0] = cmp_data_q[15:8];
      IDX_CMP_DATA_L: rd_mux[7:0] = cmp_data_q[7:0];
      default:        rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= RESP_OKAY;
    end
    else if (I_ARVALID && O_ARREADY)
    begin
      O_RVALID <= 1'b1;
      O_RDATA  <= rd_mux;
      O_RRESP  <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (I_RREADY)
      O_RVALID <= 1'b0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  a_range_write_locked: assert property (armed |=> $stable(range_q))
    else $error("range config changed while armed");
  a_cmp_addr_locked: assert property (armed |=>
    $stable(cmp_addr_q[0]) && $stable(cmp_addr_q[1]) && $stable(cmp_addr_q[2]))
    else $error("comparator address changed while armed");
  a_match1_off: assert property (range_q != 2'b00 |-> !match[1])
    else $error("match1 active outside pair mode");
  a_reserved_is_a: assert property (range_q == 2'b11 |-> match[0] == hit[0])
    else $error("reserved range code not comparator A");
  a_trace_gated: assert property (!rd_ok && ar_idx == IDX_TRACE_HI |-> rd_mux == 32'h0)
    else $error("trace data returned while locked");
  a_unlock_word: assert property (do_wr && !armed && aw_idx_q == IDX_TRACE_HI
    && wstrb_q[1:0] == 2'b11 |=> unlock_q && $stable(cnt_q))
    else $error("word write did not unlock trace buffer");
  a_c_no_size: assert property (cmp_ctl_q[2][7:6] == 2'b00
    && cmp_ctl_q[2][CC_NO_DATA] == 1'b0 && cmp_ctl_q[1][CC_NO_DATA] == 1'b0)
    else $error("unimplemented control bit set");
  a_view_none_ro: assert property (view == VIEW_NONE
    && ar_idx == IDX_CMP_ADDR_M |-> rd_mux == 32'h0)
    else $error("hidden comparator visible");
  a_addr_hit: assert property (hit[0] |->
    I_BUS_ADDR[17:8] == cmp_addr_q[0][17:8])
    else $error("comparator hit on wrong address");
  a_full_disarms: assert property (seq_q == SEQ_TRACE && full |=> !armed)
    else $error("full trace buffer kept module armed");

  c_trace_full: cover property (seq_q == SEQ_TRACE ##1 !armed);
  c_inside_hit: cover property (range_q == 2'b01 && match[0]);
  c_trace_read: cover property (tb_rd);
  c_break: cover property (O_BREAK_REQ);

endmodule

// ==== sim/cpu_bus_model.sv ====
// processor bus model that issues single read cycles on request
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_go,
  input  wire logic [17:0] i_addr,
  output logic             o_valid,
  output logic [17:0]      o_addr,
  output logic [15:0]      o_data,
  output logic             o_write,
  output logic             o_word
);
  // --------------------------------------------------
  // one cycle per request
  // --------------------------------------------------
  // idle lines toggle so a stale address never matches
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_valid <= 1'b0;
      o_addr  <= 18'h00000;
      o_data  <= 16'h0000;
    end
    else
    begin
      o_valid <= i_go;
      o_addr  <= i_go ? i_addr : ~o_addr;
      o_data  <= ~o_data;
    end
  end
  assign o_write = 1'b0;
  assign o_word  = 1'b1;
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the bus debug comparator and trace block
`timescale 1ns/1ps
module testbench;
  import dbg_cmp_pkg::*;
  localparam int TD = 8;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        unsec, go, awready, wready, bvalid, arready, rvalid;
  logic        bv, bw, bwd, armed, brk, bo;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr, bb;
  logic [17:0] ba, goaddr;
  logic [15:0] bd;
  logic [2:0]  match, mo;
  int          mismatches, n_tests;

  bus_debug_comparator_trace #(.TRACE_DEPTH(TD)) dut_u (
    .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_BUS_VALID(bv),
    .I_BUS_ADDR(ba), .I_BUS_DATA(bd), .I_BUS_WRITE(bw), .I_BUS_WORD(bwd),
    .I_CHIP_UNSECURE(unsec), .O_MATCH(match), .O_BREAK_REQ(brk), .O_ARMED(armed));

  cpu_bus_model cpu_u (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_addr(goaddr),
    .o_valid(bv), .o_addr(ba), .o_data(bd), .o_write(bw), .o_word(bwd));

  // --------------------------------------------------
  // shared tasks
  // --------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] s = 4'h1);
    @(posedge clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {16'h0000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bb = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx);
    @(posedge clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [5:0] idx, input logic [15:0] e);
    rd(idx);
    check(what, rv, {16'h0000, e});
  endtask

  // one bus cycle; match gathered over the edges that may carry it
  task automatic cyc(input logic [17:0] a);
    @(posedge clk);
    goaddr <= a;
    go     <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    mo = 3'h0;
    bo = 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      #1 mo = mo | match;
      bo = bo | brk;
    end
  endtask

  task automatic setc(input logic [7:0] v, c, h, m, l);
    wr(IDX_CTRL_ONE, {8'h00, v});
    wr(IDX_CMP_CTL, {8'h00, c});
    wr(IDX_CMP_ADDR_H, {8'h00, h});
    wr(IDX_CMP_ADDR_M, {8'h00, m});
    wr(IDX_CMP_ADDR_L, {8'h00, l});
  endtask

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_reset();
    rchk("range_cfg", IDX_RANGE_CFG, 16'h0000);
    rchk("unmapped", 6'h10, 16'h0000);
    check("unmapped_rresp", {30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(6'h3f, 16'h00aa);
    check("unmapped_bresp", {30'h0, bb}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_view();
    for (int v = 0; v < 3; v++)
      setc(v[7:0], 8'h00, 8'hfc | (v[7:0] + 8'h01), 8'h10 + v[7:0], 8'h20 + v[7:0]);
    for (int v = 0; v < 3; v++)
    begin
      wr(IDX_CTRL_ONE, 16'(v));
      rchk("addr_high", IDX_CMP_ADDR_H, 16'(v + 1));
      rchk("addr_mid", IDX_CMP_ADDR_M, 16'(v + 16));
      rchk("addr_low", IDX_CMP_ADDR_L, 16'(v + 32));
    end
    wr(IDX_CTRL_ONE, 16'h0003);
    wr(IDX_CMP_ADDR_M, 16'h0055);
    rchk("addr_none", IDX_CMP_ADDR_M, 16'h0000);
    wr(IDX_CTRL_ONE, 16'h0000);
    rchk("addr_kept", IDX_CMP_ADDR_M, 16'h0010);
  endtask

  task automatic t_ctl();
    logic [7:0] mk[3] = '{CTL_MASK_A, CTL_MASK_B, CTL_MASK_C};
    for (int v = 0; v < 3; v++)
    begin
      wr(IDX_CTRL_ONE, 16'(v));
      wr(IDX_CMP_CTL, 16'h00ff);
      rchk("cmp_ctl", IDX_CMP_CTL, {8'h00, mk[v]});
    end
  endtask

  task automatic t_match();
    logic [17:0] ad[5] = '{18'h12345, 18'h12400, 18'h12380, 18'h02345, 18'h12445};
    logic [2:0]  ex[4][5] = '{'{1, 2, 0, 0, 0}, '{1, 1, 1, 0, 0},
                              '{0, 0, 0, 1, 1}, '{1, 0, 0, 0, 0}};
    setc(8'h01, 8'h01, 8'h01, 8'h24, 8'h00);
    setc(8'h02, 8'h00, 8'h00, 8'h00, 8'h00);
    setc(8'h00, 8'h03, 8'h01, 8'h23, 8'h45);
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_RANGE_CFG, 16'(c));
      // arm with break enable so every match also raises a break
      wr(IDX_CTRL_ONE, 16'h0088);
      wr(IDX_RANGE_CFG, 16'(c ^ 1));
      wr(IDX_CMP_ADDR_M, 16'h0099);
      rchk("range_armed", IDX_RANGE_CFG, 16'(c));
      for (int a = 0; a < 5; a++)
      begin
        cyc(ad[a]);
        check("match", {29'h0, mo}, {29'h0, ex[c][a]});
        check("break", {31'h0, bo}, {31'h0, |ex[c][a]});
      end
      wr(IDX_CTRL_ONE, 16'h0000);
      rchk("addr_armed", IDX_CMP_ADDR_M, 16'h0023);
    end
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      wr(IDX_TRACE_CTL, 16'(8'h40 | (m << TRC_MODE)));
      rchk("trace_mode", IDX_TRACE_CTL, 16'(8'h40 | (m << TRC_MODE)));
    end
    // loop1 keeps one of three repeats, detail keeps all, pure PC drops the steps
    for (int m = 1; m < 4; m++)
    begin
      wr(IDX_TRACE_CTL, 16'(8'h40 | (m << TRC_MODE)));
      wr(IDX_CTRL_ONE, 16'h0080);
      wr(IDX_CTRL_ONE, 16'h00c0);
      for (int a = 0; a < 3; a++)
        cyc(18'h12345 + 18'(a * (m / 2)));
      rchk("trace_count", IDX_TRACE_CNT, (m == 2) ? 16'h0003 : 16'h0001);
      wr(IDX_CTRL_ONE, 16'h0000);
    end
  endtask

  // fills the buffer, then walks the unlock, secure and source read conditions
  task automatic t_trace();
    wr(IDX_TRACE_CTL, 16'h0040);
    wr(IDX_CTRL_ONE, 16'h00c0);
    repeat (TD + 2) cyc(18'h12345);
    check("armed_full", {31'h0, armed}, 32'h0);
    rchk("trace_locked", IDX_TRACE_HI, 16'h0000);
    wr(IDX_TRACE_HI, 16'hffff, 4'h3);
    rchk("trace_secure", IDX_TRACE_HI, 16'h0000);
    @(posedge clk);
    unsec <= 1'b1;
    rchk("trace_word", IDX_TRACE_HI, 16'h2345);
    rchk("trace_low", IDX_TRACE_LO, 16'h0045);
    wr(IDX_TRACE_CTL, 16'h0000);
    rchk("trace_nosrc", IDX_TRACE_HI, 16'h0000);
    // reset in mid-run: registers clear, stored entries survive
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk("range_reset", IDX_RANGE_CFG, 16'h0000);
    wr(IDX_TRACE_CTL, 16'h0040);
    rchk("trace_relocked", IDX_TRACE_HI, 16'h0000);
    wr(IDX_TRACE_HI, 16'h0000, 4'h3);
    rchk("trace_kept", IDX_TRACE_HI, 16'h2345);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // --------------------------------------------------
  // clock, watchdog, main sequence
  // --------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run is well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, go, unsec} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata  = 32'h0;
    wstrb  = 4'h0;
    goaddr = 18'h00000;
    rst_n  = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_view();
    t_ctl();
    t_match();
    t_modes();
    t_trace();
    print_verdict();
  end
endmodule
